/* File: inc/uasr_pkg.sv */
package uasr_pkg;

  // register byte offsets, decoded on the low address bits
  localparam int unsigned DEC_W = 12;
  localparam logic [11:0] UART_OPTS_OFFSET = 12'h000;
  localparam logic [11:0] ADC_OPTS_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  // values after reset
  localparam logic [31:0] UART_OPTS_RESET = 32'h0000_0000;
  localparam logic [31:0] ADC_OPTS_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // writable bits; everything else is reserved and reads zero
  localparam logic [31:0] UART_OPTS_MASK = 32'h0007_0077;
  localparam logic [31:0] ADC_OPTS_MASK = 32'h0000_009f;

  // uart routing field layout, repeating per uart instance
  localparam int unsigned NUM_ROUTED_UARTS = 2;
  localparam int unsigned NUM_OD_UARTS = 3;
  localparam int unsigned UART_FIELD_STRIDE = 4;
  localparam int unsigned UART_TX_LSB = 0;
  localparam int unsigned UART_TX_W = 2;
  localparam int unsigned UART_RX_BIT = 2;
  localparam int unsigned UART_OD_LSB = 16;

  // adc trigger field layout
  localparam int unsigned ADC_CODE_LSB = 0;
  localparam int unsigned ADC_CODE_W = 4;
  localparam int unsigned ADC_PRE_BIT = 4;
  localparam int unsigned ADC_ALT_BIT = 7;

  // status register bit positions (live routed levels)
  localparam int unsigned STAT_RX_LSB = 0;
  localparam int unsigned STAT_TX_LSB = 2;
  localparam int unsigned STAT_TRIG_A_BIT = 4;
  localparam int unsigned STAT_TRIG_B_BIT = 5;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic HRESP_OKAY = 1'b0;

  // transmit path codes
  typedef enum logic [1:0] {
    TX_PLAIN = 2'b00,
    TX_MOD_TIMER_ONE = 2'b01,
    TX_MOD_TIMER_TWO = 2'b10,
    TX_RESERVED = 2'b11
  } uasr_tx_path_e;

  // alternate trigger codes
  typedef enum logic [3:0] {
    TRG_EXTERNAL = 4'h0,
    TRG_COMPARATOR = 4'h1,
    TRG_PERIODIC0 = 4'h4,
    TRG_PERIODIC1 = 4'h5,
    TRG_TIMER_ZERO_OVF = 4'h8,
    TRG_TIMER_ONE_OVF = 4'h9,
    TRG_TIMER_TWO_OVF = 4'ha,
    TRG_RTC_ALARM = 4'hc,
    TRG_RTC_SECONDS = 4'hd,
    TRG_LOW_POWER_TIMER = 4'he
  } uasr_trig_code_e;

  // register selected by the pending data phase
  typedef enum logic [1:0] {SEL_NONE, SEL_UART, SEL_ADC, SEL_STATUS} uasr_reg_sel_e;

  typedef struct packed {
    logic receive_pin;
    logic transmit_data;
  } uasr_uart_in_s;

  typedef struct packed {
    logic receive_data;
    logic transmit_pin;
  } uasr_uart_out_s;

  typedef struct packed {
    logic receive_from_comparator;
    uasr_tx_path_e transmit_path;
  } uasr_uart_cfg_s;

  typedef struct packed {
    logic alternate_en;
    logic pretrigger_b;
    logic [3:0] code;
  } uasr_adc_cfg_s;

  typedef struct packed {
    logic external_trigger_input;
    logic periodic_trigger0;
    logic periodic_trigger1;
    logic timer_zero_overflow;
    logic timer_one_overflow;
    logic timer_two_overflow;
    logic rtc_alarm;
    logic rtc_seconds;
    logic low_power_timer_trigger;
    logic timer_one_ch0;
    logic timer_one_ch1;
  } uasr_trig_src_s;

endpackage

/* File: hdl/uasr_uart_route.sv */
`timescale 1ns/1ps
`default_nettype none
module uasr_uart_route (
  input wire uasr_pkg::uasr_uart_cfg_s cfg_i,
  input wire uasr_pkg::uasr_uart_in_s uart_i,
  input wire logic comparator_zero_i,
  input wire logic timer_one_ch0_i,
  input wire logic timer_two_ch0_i,
  output uasr_pkg::uasr_uart_out_s uart_o
);

  // purely combinational so a field change takes effect at once
  always_comb
  begin
    // receive source: own pin or comparator output
    uart_o.receive_data = cfg_i.receive_from_comparator ? comparator_zero_i : uart_i.receive_pin;
    // modulation gates the carrier onto low bits only, so the idle line stays high
    case (cfg_i.transmit_path)
      uasr_pkg::TX_PLAIN:
      begin
        uart_o.transmit_pin = uart_i.transmit_data;
      end
      uasr_pkg::TX_MOD_TIMER_ONE:
      begin
        uart_o.transmit_pin = uart_i.transmit_data | timer_one_ch0_i;
      end
      uasr_pkg::TX_MOD_TIMER_TWO:
      begin
        uart_o.transmit_pin = uart_i.transmit_data | timer_two_ch0_i;
      end
      default:
      begin
        // reserved code falls back to the plain pin
        uart_o.transmit_pin = uart_i.transmit_data;
      end
    endcase
  end

endmodule // uasr_uart_route
`default_nettype wire

/* File: hdl/uasr_adc_trig.sv */
`timescale 1ns/1ps
`default_nettype none
module uasr_adc_trig (
  input wire uasr_pkg::uasr_adc_cfg_s cfg_i,
  input wire uasr_pkg::uasr_trig_src_s src_i,
  input wire logic comparator_zero_i,
  output logic trig_a_o,
  output logic trig_b_o
);

  logic alt_trig; // selected alternate source level

  // alternate source decode; reserved codes give a quiet trigger
  always_comb
  begin
    case (cfg_i.code)
      uasr_pkg::TRG_EXTERNAL: alt_trig = src_i.external_trigger_input;
      uasr_pkg::TRG_COMPARATOR: alt_trig = comparator_zero_i;
      uasr_pkg::TRG_PERIODIC0: alt_trig = src_i.periodic_trigger0;
      uasr_pkg::TRG_PERIODIC1: alt_trig = src_i.periodic_trigger1;
      uasr_pkg::TRG_TIMER_ZERO_OVF: alt_trig = src_i.timer_zero_overflow;
      uasr_pkg::TRG_TIMER_ONE_OVF: alt_trig = src_i.timer_one_overflow;
      uasr_pkg::TRG_TIMER_TWO_OVF: alt_trig = src_i.timer_two_overflow;
      uasr_pkg::TRG_RTC_ALARM: alt_trig = src_i.rtc_alarm;
      uasr_pkg::TRG_RTC_SECONDS: alt_trig = src_i.rtc_seconds;
      uasr_pkg::TRG_LOW_POWER_TIMER: alt_trig = src_i.low_power_timer_trigger;
      default: alt_trig = 1'b0;
    endcase
  end

  // scheme select: timer one channels, or alternate with pre-trigger choice
  always_comb
  begin
    if (cfg_i.alternate_en)
    begin
      trig_a_o = alt_trig & ~cfg_i.pretrigger_b;
      trig_b_o = alt_trig & cfg_i.pretrigger_b;
    end
    else
    begin
      trig_a_o = src_i.timer_one_ch0;
      trig_b_o = src_i.timer_one_ch1;
    end
  end

endmodule // uasr_adc_trig
`default_nettype wire

/* File: hdl/uasr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module uasr_top (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CLK_EN_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // routed uart signals
  input wire uasr_pkg::uasr_uart_in_s [1:0] UART_I,
  output uasr_pkg::uasr_uart_out_s [1:0] UART_O,
  output logic [2:0] UART_OPEN_DRAIN_EN_O,
  // trigger sources and comparator/timer levels
  input wire logic COMPARATOR_ZERO_I,
  input wire logic TIMER_ONE_CH0_I,
  input wire logic TIMER_TWO_CH0_I,
  input wire uasr_pkg::uasr_trig_src_s TRIG_SRC_I,
  // adc conversion triggers
  output logic ADC_TRIG_A_O,
  output logic ADC_TRIG_B_O
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  // whole module state in one record
  // one record keeps the freeze and the reset in a single place,
  // and the clock enable then gates it all at once
  typedef struct packed {
    logic dp_active; // a data phase is pending
    logic dp_write; // pending phase is a write
    uasr_pkg::uasr_reg_sel_e dp_sel; // register hit by the pending phase
    logic [31:0] uart_opts; // uart routing options
    logic [31:0] adc_opts; // adc trigger options
    logic [31:0] rdata; // captured read data
  } uasr_top_state_s;

  uasr_top_state_s st; // registered state
  uasr_top_state_s next_st; // next state

  // bus side
  logic addr_accept; // address phase taken this cycle
  logic data_write; // data phase write completes this cycle
  uasr_pkg::uasr_reg_sel_e addr_sel; // decode of the current address
  // read side
  logic [31:0] status_view; // live routed levels
  logic [31:0] read_mux; // read value for the current address
  logic [31:0] fwd_uart; // uart options as they stand after this cycle
  logic [31:0] fwd_adc; // adc options as they stand after this cycle
  // routing side
  uasr_pkg::uasr_uart_cfg_s [1:0] uart_cfg; // per-uart routing fields
  uasr_pkg::uasr_adc_cfg_s adc_cfg; // adc trigger fields
  logic trig_a; // routed trigger a
  logic trig_b; // routed trigger b

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // the slave adds no wait state of its own; the only stall comes
  // from the clock enable, which also keeps a data phase pending
  // take an address phase only while the clock enable lets the bus move
  assign addr_accept = CLK_EN_I & HSEL_I & HREADY_I & (HTRANS_I == uasr_pkg::HTRANS_NONSEQ);

  // only full-word writes land; narrower ones are dropped, no lane merging
  // the size is checked in the address phase and carried in dp_write
  assign data_write = CLK_EN_I & st.dp_active & st.dp_write;

  // address decode on the low bits; anything else is unmapped
  // the map aliases across the address space above the decoded bits
  always_comb
  begin
    case (HADDR_I[uasr_pkg::DEC_W-1:0])
      uasr_pkg::UART_OPTS_OFFSET:
      begin
        addr_sel = uasr_pkg::SEL_UART;
      end
      uasr_pkg::ADC_OPTS_OFFSET:
      begin
        addr_sel = uasr_pkg::SEL_ADC;
      end
      uasr_pkg::STATUS_OFFSET:
      begin
        addr_sel = uasr_pkg::SEL_STATUS;
      end
      default:
      begin
        // unmapped offsets read zero and drop writes
        addr_sel = uasr_pkg::SEL_NONE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // single combinational builder of the next state
  // every field defaults to its stored value, so nothing latches
  always_comb
  begin
    next_st = st;
    // write completes in its data phase, masked so reserved bits stay zero
    // only the two option registers take writes
    if (data_write)
    begin
      case (st.dp_sel)
        uasr_pkg::SEL_UART:
        begin
          next_st.uart_opts = HWDATA_I & uasr_pkg::UART_OPTS_MASK;
        end
        uasr_pkg::SEL_ADC:
        begin
          next_st.adc_opts = HWDATA_I & uasr_pkg::ADC_OPTS_MASK;
        end
        default:
        begin
          // status and unmapped writes are ignored
          next_st.adc_opts = st.adc_opts;
        end
      endcase
    end
    // the pending phase ends whenever the enable lets the bus advance
    // a frozen enable keeps the phase pending, so a stalled write lands once
    if (CLK_EN_I)
    begin
      next_st.dp_active = addr_accept;
      next_st.dp_write = addr_accept & HWRITE_I & (HSIZE_I == uasr_pkg::HSIZE_WORD);
      next_st.dp_sel = addr_accept ? addr_sel : uasr_pkg::SEL_NONE;
    end
    // read data sampled in the address phase from the post-write values
    // writes leave rdata alone, so HRDATA_O keeps the last read
    if (addr_accept & ~HWRITE_I)
    begin
      next_st.rdata = read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // status view gathers the routed levels the block drives right now
  // it is read only, and the bits above the trigger levels stay zero
  always_comb
  begin
    status_view = 32'h0000_0000;
    // uart levels first
    status_view[uasr_pkg::STAT_RX_LSB] = UART_O[0].receive_data;
    status_view[uasr_pkg::STAT_RX_LSB+1] = UART_O[1].receive_data;
    status_view[uasr_pkg::STAT_TX_LSB] = UART_O[0].transmit_pin;
    status_view[uasr_pkg::STAT_TX_LSB+1] = UART_O[1].transmit_pin;
    // then the two trigger levels
    status_view[uasr_pkg::STAT_TRIG_A_BIT] = trig_a;
    status_view[uasr_pkg::STAT_TRIG_B_BIT] = trig_b;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write forwarding

  // a write finishing this cycle is forwarded, so a read taken in the
  // same cycle returns the new value; built from st and the data phase,
  // not from next_st, to keep read_mux out of a combinational loop
  always_comb
  begin
    fwd_uart = st.uart_opts; // no write pending: stored value
    fwd_adc = st.adc_opts; // no write pending: stored value
    if (data_write && (st.dp_sel == uasr_pkg::SEL_UART))
    begin
      fwd_uart = HWDATA_I; // masked at the read mux
    end
    if (data_write && (st.dp_sel == uasr_pkg::SEL_ADC))
    begin
      fwd_adc = HWDATA_I; // masked at the read mux
    end
  end

  // read value for the address now presented
  always_comb
  begin
    case (addr_sel)
      uasr_pkg::SEL_UART:
      begin
        read_mux = fwd_uart & uasr_pkg::UART_OPTS_MASK;
      end
      uasr_pkg::SEL_ADC:
      begin
        read_mux = fwd_adc & uasr_pkg::ADC_OPTS_MASK;
      end
      uasr_pkg::SEL_STATUS:
      begin
        read_mux = status_view;
      end
      default:
      begin
        // unmapped space reads zero
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // reset wins over the clock enable; otherwise enable low freezes all
  // a synchronous reset keeps every flop on the edge of the bus clock
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      // bus tracking back to idle
      st.dp_active <= 1'b0;
      st.dp_write <= 1'b0;
      st.dp_sel <= uasr_pkg::SEL_NONE;
      // option registers back to their values after reset
      st.uart_opts <= uasr_pkg::UART_OPTS_RESET;
      st.adc_opts <= uasr_pkg::ADC_OPTS_RESET;
      st.rdata <= uasr_pkg::RDATA_RESET;
    end
    else if (CLK_EN_I)
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus outputs

  // zero wait states; stalling only while the enable is low
  // refused accesses read zero, so no error response is needed
  // HRDATA_O comes from a flop and stands through the data phase
  assign HREADYOUT_O = CLK_EN_I;
  assign HRESP_O = uasr_pkg::HRESP_OKAY;
  assign HRDATA_O = st.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // routing

  // open-drain enables straight from the stored bits
  // uart2 has no routing fields, only this enable
  assign UART_OPEN_DRAIN_EN_O = st.uart_opts[uasr_pkg::UART_OD_LSB +: uasr_pkg::NUM_OD_UARTS];

  // one routing slice per uart, fields repeat at a fixed stride
  // each slice is four bits: tx path, rx select, one reserved bit
  genvar gi;
  generate
    for (gi = 0; gi < uasr_pkg::NUM_ROUTED_UARTS; gi = gi + 1)
    begin : g_uart
      localparam int unsigned BASE = gi * uasr_pkg::UART_FIELD_STRIDE;
      // field extraction for this uart
      assign uart_cfg[gi].receive_from_comparator = st.uart_opts[BASE + uasr_pkg::UART_RX_BIT];
      assign uart_cfg[gi].transmit_path =
        uasr_pkg::uasr_tx_path_e'(st.uart_opts[BASE + uasr_pkg::UART_TX_LSB +: uasr_pkg::UART_TX_W]);

      // the routing slice itself is purely combinational
      uasr_uart_route u_route (
        .cfg_i(uart_cfg[gi]),
        .uart_i(UART_I[gi]),
        .comparator_zero_i(COMPARATOR_ZERO_I),
        .timer_one_ch0_i(TIMER_ONE_CH0_I),
        .timer_two_ch0_i(TIMER_TWO_CH0_I),
        .uart_o(UART_O[gi])
      );
    end
  endgenerate

  // adc trigger fields from the stored register
  // the pre-trigger bit is ignored while the timer scheme is chosen
  assign adc_cfg.alternate_en = st.adc_opts[uasr_pkg::ADC_ALT_BIT];
  assign adc_cfg.pretrigger_b = st.adc_opts[uasr_pkg::ADC_PRE_BIT];
  assign adc_cfg.code = st.adc_opts[uasr_pkg::ADC_CODE_LSB +: uasr_pkg::ADC_CODE_W];

  // trigger selection is combinational, no added latency
  // both outputs are levels; edge detection is the converter's job
  uasr_adc_trig u_trig (
    .cfg_i(adc_cfg),
    .src_i(TRIG_SRC_I),
    .comparator_zero_i(COMPARATOR_ZERO_I),
    .trig_a_o(trig_a),
    .trig_b_o(trig_b)
  );

  // routed levels leave with no flop in between
  assign ADC_TRIG_A_O = trig_a;
  assign ADC_TRIG_B_O = trig_b;

endmodule // uasr_top
`default_nettype wire

/* File: verif/uasr_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module uasr_top_monitor (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CLK_EN_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic HREADYOUT_O,
  input wire uasr_pkg::uasr_uart_in_s [1:0] UART_I,
  input wire uasr_pkg::uasr_uart_out_s [1:0] UART_O,
  input wire logic [2:0] UART_OPEN_DRAIN_EN_O,
  input wire uasr_pkg::uasr_trig_src_s TRIG_SRC_I,
  input wire logic ADC_TRIG_A_O,
  input wire logic ADC_TRIG_B_O
);
  default clocking mon_cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  ////////////////////////////////////////
  logic take, land_u, land_a, pend_u, pend_a, seen_u, seen_a; // bus tracking
  logic [2:0] wd_od; // open drain bits of the last data phase
  // address phase accepted by the slave
  assign take = HSEL_I && HREADY_I && (HTRANS_I == uasr_pkg::HTRANS_NONSEQ) && CLK_EN_I;
  assign land_u = pend_u && HREADY_I && CLK_EN_I;
  assign land_a = pend_a && HREADY_I && CLK_EN_I;
  // pending word writes; seen flags are conservative, a write of zero also sets them
  always_ff @(posedge CORE_CLK_I)
  begin
    wd_od <= HWDATA_I[18:16];
    if (SYS_RST_I)
    begin
      pend_u <= 1'b0;
      pend_a <= 1'b0;
      seen_u <= 1'b0;
      seen_a <= 1'b0;
    end
    else
    begin
      if (HREADY_I && CLK_EN_I)
      begin
        pend_u <= take && HWRITE_I && HSIZE_I == uasr_pkg::HSIZE_WORD && HADDR_I[11:0] == uasr_pkg::UART_OPTS_OFFSET;
        pend_a <= take && HWRITE_I && HSIZE_I == uasr_pkg::HSIZE_WORD && HADDR_I[11:0] == uasr_pkg::ADC_OPTS_OFFSET;
      end
      seen_u <= seen_u || land_u;
      seen_a <= seen_a || land_a;
    end
  end
  ////////////////////////////////////////
  a_uart_reserved_zero:
    assert property (take && !HWRITE_I && HADDR_I[11:0] == uasr_pkg::UART_OPTS_OFFSET
      |=> (HRDATA_O & ~uasr_pkg::UART_OPTS_MASK) == 32'h0000_0000) else $error("uart reserved bits not zero");
  a_adc_reserved_zero:
    assert property (take && !HWRITE_I && HADDR_I[11:0] == uasr_pkg::ADC_OPTS_OFFSET
      |=> (HRDATA_O & ~uasr_pkg::ADC_OPTS_MASK) == 32'h0000_0000) else $error("adc reserved bits not zero");
  a_odrain_readback:
    assert property (take && !HWRITE_I && HADDR_I[11:0] == uasr_pkg::UART_OPTS_OFFSET
      |=> HRDATA_O[18:16] == UART_OPEN_DRAIN_EN_O) else $error("open drain readback differs");
  a_odrain_write:
    assert property (land_u |=> UART_OPEN_DRAIN_EN_O == wd_od) else $error("open drain not written");
  a_odrain_hold:
    assert property ($changed(UART_OPEN_DRAIN_EN_O) && !$past(SYS_RST_I) |-> $past(land_u))
      else $error("open drain changed without write");
  a_tx_reset_path:
    assert property (!seen_u |-> UART_O[0].transmit_pin == UART_I[0].transmit_data
      && UART_O[1].transmit_pin == UART_I[1].transmit_data && UART_O[0].receive_data == UART_I[0].receive_pin
      && UART_O[1].receive_data == UART_I[1].receive_pin) else $error("default uart path wrong");
  a_trig_timer_mode:
    assert property (!seen_a |-> ADC_TRIG_A_O == TRIG_SRC_I.timer_one_ch0 && ADC_TRIG_B_O == TRIG_SRC_I.timer_one_ch1)
      else $error("timer trigger mode wrong");
  a_trig_exclusive:
    assert property (ADC_TRIG_A_O && ADC_TRIG_B_O |-> TRIG_SRC_I.timer_one_ch0 && TRIG_SRC_I.timer_one_ch1)
      else $error("both pretriggers fired");
  a_ready_follows:
    assert property (HREADYOUT_O == CLK_EN_I) else $error("ready not following enable");
endmodule // uasr_top_monitor
bind uasr_top uasr_top_monitor u_mon (.CORE_CLK_I, .SYS_RST_I, .CLK_EN_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I,
  .HSIZE_I, .HWDATA_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O, .UART_I, .UART_O, .UART_OPEN_DRAIN_EN_O, .TRIG_SRC_I,
  .ADC_TRIG_A_O, .ADC_TRIG_B_O);
`default_nettype wire

/* File: verif/uasr_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: uart pins, comparator, timer channels and trigger sources as plain levels
module uasr_far_model (
  input wire logic [17:0] lvl_i,
  output uasr_pkg::uasr_uart_in_s [1:0] uart_o,
  output logic cmp_o,
  output logic t1_o,
  output logic t2_o,
  output uasr_pkg::uasr_trig_src_s src_o
);
  // these wires carry no handshake, so the model only presents levels
  assign {uart_o, cmp_o, t1_o, t2_o, src_o} = lvl_i;
endmodule // uasr_far_model
`default_nettype wire

/* File: verif/uasr_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module uasr_top_bench;
  logic clk, rst, cen, hsel, hwrite, hresp, ta, tb; // bus and trigger wires
  logic [31:0] haddr, hwdata, hrdata, uopt, aopt, q; // uopt and aopt mirror the fields
  logic [1:0] htrans;
  logic [2:0] hsize, od;
  logic [17:0] lvl; // far-side levels
  wire logic hrdy; // single slave, so its ready is the bus ready
  uasr_pkg::uasr_uart_in_s [1:0] ui;
  uasr_pkg::uasr_uart_out_s [1:0] uo;
  uasr_pkg::uasr_trig_src_s src;
  logic cmp, t1, t2;
  int errors, n_compared;
  logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he};
  ////////////////////////////////////////
  uasr_top dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(cen), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .UART_I(ui), .UART_O(uo), .UART_OPEN_DRAIN_EN_O(od),
    .COMPARATOR_ZERO_I(cmp), .TIMER_ONE_CH0_I(t1), .TIMER_TWO_CH0_I(t2), .TRIG_SRC_I(src),
    .ADC_TRIG_A_O(ta), .ADC_TRIG_B_O(tb));
  uasr_far_model far (.lvl_i(lvl), .uart_o(ui), .cmp_o(cmp), .t1_o(t1), .t2_o(t2), .src_o(src));
  // 250 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer: address phase, then data phase; waits on ready without assuming latency
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz);
    hsel <= 1'b1;
    htrans <= uasr_pkg::HTRANS_NONSEQ;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    hsize <= sz;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, uasr_pkg::HSIZE_WORD);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, uasr_pkg::HSIZE_WORD);
    chk(q, exp);
    chk({31'h0, hresp}, {31'h0, uasr_pkg::HRESP_OKAY});
  endtask
  // read address phase rides in the data phase of the write to the same word
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, uasr_pkg::HTRANS_NONSEQ, 20'h00000, a, 1'b1, uasr_pkg::HSIZE_WORD};
    do @(posedge clk); while (hrdy !== 1'b1);
    {hwrite, hwdata} <= {1'b0, d};
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    do @(posedge clk); while (hrdy !== 1'b1);
    chk(hrdata, exp);
  endtask
  // expected {rx1, rx0, tx1, tx0, open drain, trig a, trig b}; only valid trigger codes reach here
  function automatic logic [8:0] route_exp(input logic [31:0] u, input logic [31:0] ad, input logic [17:0] v);
    uasr_pkg::uasr_uart_in_s [1:0] pi;
    uasr_pkg::uasr_trig_src_s s;
    logic c, p1, p2, alt;
    logic [1:0] rx, tx;
    {pi, c, p1, p2, s} = v;
    for (int i = 0; i < 2; i++)
    begin
      rx[i] = u[4 * i + 2] ? c : pi[i].receive_pin;
      tx[i] = pi[i].transmit_data | (u[4 * i +: 2] == 2'b01 && p1) | (u[4 * i +: 2] == 2'b10 && p2);
    end
    case (ad[3:0])
      4'h0: alt = s.external_trigger_input;
      4'h1: alt = c;
      4'h4: alt = s.periodic_trigger0;
      4'h5: alt = s.periodic_trigger1;
      4'h8: alt = s.timer_zero_overflow;
      4'h9: alt = s.timer_one_overflow;
      4'ha: alt = s.timer_two_overflow;
      4'hc: alt = s.rtc_alarm;
      4'hd: alt = s.rtc_seconds;
      default: alt = s.low_power_timer_trigger;
    endcase
    if (ad[7])
      return {rx, tx, u[18:16], alt & ~ad[4], alt & ad[4]};
    return {rx, tx, u[18:16], s.timer_one_ch0, s.timer_one_ch1};
  endfunction
  // walk a one-hot level through every source, then all low and all high
  task automatic sweep();
    logic [8:0] e; // expected routed levels
    for (int k = 0; k < 20; k++)
    begin
      lvl <= (k < 18) ? (18'h00001 << k) : {18{k[0]}};
      @(negedge clk);
      e = route_exp(uopt, aopt, lvl);
      chk({23'h0, uo[1].receive_data, uo[0].receive_data, uo[1].transmit_pin, uo[0].transmit_pin, od, ta, tb},
        {23'h0, e});
      @(posedge clk);
      rd_chk(uasr_pkg::STATUS_OFFSET, {26'h0, e[0], e[1], e[6], e[5], e[8], e[7]});
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // a hang is cut short well past the expected run of about 2000 cycles
  initial
  begin
    #40000;
    errors++;
    give_verdict();
  end
  initial
  begin
    errors = 0;
    n_compared = 0;
    {rst, cen, hsel, haddr, htrans, hwrite, hsize, hwdata, lvl, uopt, aopt} = {1'b1, 1'b1, 153'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(uasr_pkg::UART_OPTS_OFFSET, uasr_pkg::UART_OPTS_RESET);
    rd_chk(uasr_pkg::ADC_OPTS_OFFSET, uasr_pkg::ADC_OPTS_RESET);
    rd_chk(12'h00c, 32'h0000_0000);
    sweep();
    wr(uasr_pkg::UART_OPTS_OFFSET, 32'hffff_ffff);
    rd_chk(uasr_pkg::UART_OPTS_OFFSET, 32'h0007_0077);
    wr(uasr_pkg::ADC_OPTS_OFFSET, 32'hffff_ffff);
    rd_chk(uasr_pkg::ADC_OPTS_OFFSET, 32'h0000_009f);
    bus(1'b1, uasr_pkg::UART_OPTS_OFFSET, 32'h0000_0000, 3'b000);
    wr(12'h00c, 32'h0000_0000);
    rd_chk(uasr_pkg::UART_OPTS_OFFSET, 32'h0007_0077);
    // write stalled by a frozen clock enable must still land once
    cen <= 1'b0;
    fork
      wr(uasr_pkg::ADC_OPTS_OFFSET, 32'h0000_0000);
      begin
        repeat (5) @(posedge clk);
        cen <= 1'b1;
      end
    join
    rd_chk(uasr_pkg::ADC_OPTS_OFFSET, 32'h0000_0000);
    // open drain bits one at a time, then transmit and receive combinations
    for (int m = 0; m < 9; m++)
    begin
      uopt = (m < 3) ? (32'h0001_0000 << m) : {25'h0, m[0], 2'(m % 3), 1'b0, ~m[0], 2'(2 - m % 3)};
      wr(uasr_pkg::UART_OPTS_OFFSET, uopt);
      sweep();
    end
    // every valid trigger code with both pre-triggers; reserved codes are never swept
    for (int n = 0; n < 21; n++)
    begin
      aopt = (n == 20) ? 32'h0000_0011 : {24'h0, 1'b1, 2'b00, n[0], codes[n / 2]};
      wr(uasr_pkg::ADC_OPTS_OFFSET, aopt);
      sweep();
    end
    wr_rd(uasr_pkg::UART_OPTS_OFFSET, 32'hffff_ffff, 32'h0007_0077);
    // mid-run reset returns every field to zero
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    {uopt, aopt} = 64'h0;
    rd_chk(uasr_pkg::UART_OPTS_OFFSET, 32'h0000_0000);
    sweep();
    give_verdict();
  end
endmodule // uasr_top_bench
`default_nettype wire
